// [rtl/smp_pkg.sv]
// shared constants and types for the serial microstep position logic
package smp_pkg;

	// ****************************************
	// phase index and serial frame
	// ****************************************
	localparam int IDX_W       = 6;
	localparam int FRAME_W     = 16;
	localparam int BITS_W      = 5;
	localparam logic [BITS_W-1:0] FRAME_BITS = 5'h10;
	localparam int ADDR_HI     = 15;
	localparam int ADDR_LO     = 14;
	localparam int WR_BIT      = 13;
	localparam logic [1:0] RA_CONFIG0 = 2'h0;
	localparam logic [1:0] RA_TABLE   = 2'h1;
	localparam logic [1:0] RA_RUN     = 2'h3;
	localparam int SC_HI       = 5;
	localparam int SC_LO       = 0;
	localparam int RUN_CFG_HI  = 11;
	localparam int RUN_CFG_LO  = 6;
	localparam int RUN_EN_BIT  = 6;
	localparam int RES_LO_BIT  = 0;
	localparam int RES_HI_BIT  = 1;
	localparam int TBL_CLR_BIT = 6;
	localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;

	// ****************************************
	// phase current table
	// ****************************************
	localparam int MAG_W    = 6;
	localparam int PT_N     = 16;
	localparam int PT_PTR_W = 4;
	localparam logic [IDX_W-1:0] PHASE_B_SHIFT = 6'h10;
	localparam logic [MAG_W-1:0] PT_DEFAULT [PT_N] = '{
		6'h05, 6'h0b, 6'h12, 6'h17, 6'h1d, 6'h23, 6'h28, 6'h2c,
		6'h30, 6'h34, 6'h37, 6'h3a, 6'h3c, 6'h3e, 6'h3f, 6'h3f};

	// ****************************************
	// software register port
	// ****************************************
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 32;
	localparam logic [BUS_AW-1:0] OFF_STATUS  = 4'h0;
	localparam logic [BUS_AW-1:0] OFF_CURRENT = 4'h4;
	localparam logic [BUS_AW-1:0] OFF_CONFIG  = 4'h8;
	localparam logic [BUS_AW-1:0] OFF_CTRL    = 4'hc;
	localparam int CTRL_RESTORE_BIT = 0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS      = 100;
	localparam int STROBE_HIGH_MIN_NS = 500;
	localparam int STROBE_HIGH_MIN_CYC =
		(STROBE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum {SMP_IDLE, SMP_FRAME, SMP_DECODE} smp_link_state_t;

endpackage

// [rtl/smp_table_if.sv]
// carrier between the position logic and the phase current table
interface smp_table_if;
	logic [5:0] index;
	logic [5:0] mag [2];
	logic       neg [2];
	logic       wr_en;
	logic [3:0] wr_ptr;
	logic [5:0] wr_data;
	logic       restore;

	modport table_side (input index, input wr_en, input wr_ptr, input wr_data,
		input restore, output mag, output neg);
	modport user_side (output index, output wr_en, output wr_ptr, output wr_data,
		output restore, input mag, input neg);
endinterface

// [rtl/smp_link_rx.sv]
// serial link receiver, runs on the link clock
module smp_link_rx
	import smp_pkg::*;
(
	input  wire logic               sck_i,
	input  wire logic               sdi_i,
	input  wire logic               serial_strobe_n_i,
	output logic [FRAME_W-1:0]      word_o,
	output logic [BITS_W-1:0]       bits_o
);

	logic first_edge;

	// ****************************************
	// shift and bit count
	// ****************************************
	// armed while the strobe is high, dropped by the first link clock edge;
	// the count must survive the strobe rise, as the other domain reads it
	// only after that rise, and word and count stay put until the next frame
	always_ff @(posedge sck_i or posedge serial_strobe_n_i) begin
		if (serial_strobe_n_i) begin
			first_edge <= 1'b1;
		end else begin
			first_edge <= 1'b0;
		end
	end

	always_ff @(posedge sck_i) begin
		if (first_edge) begin
			bits_o <= 5'h01;
		end else if (bits_o != '1) begin
			bits_o <= bits_o + 5'h01;
		end
	end

	always_ff @(posedge sck_i) begin
		word_o <= {word_o[FRAME_W-2:0], sdi_i};
	end

endmodule

// [rtl/smp_phase_table.sv]
// phase current table with default profile and quadrant folding
module smp_phase_table
	import smp_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	smp_table_if.table_side tbl
);

	logic [MAG_W-1:0] pt [PT_N];

	// ****************************************
	// entry storage
	// ****************************************
	for (genvar e = 0; e < PT_N; e++) begin : g_entry
		always_ff @(posedge clk_i) begin
			if (rst_i || tbl.restore) begin
				pt[e] <= PT_DEFAULT[e]; // see R12
			end else if (tbl.wr_en && tbl.wr_ptr == PT_PTR_W'(e)) begin
				pt[e] <= tbl.wr_data; // see R11
			end
		end
	end

	// ****************************************
	// lookup, phase b runs 16 steps ahead of a
	// ****************************************
	for (genvar p = 0; p < 2; p++) begin : g_phase
		wire [IDX_W-1:0]    idx  = tbl.index + (p == 1 ? PHASE_B_SHIFT : 6'h00);
		wire [PT_PTR_W-1:0] off  = idx[3:0];
		wire [PT_PTR_W-1:0] up   = off - 4'h1;
		wire [PT_PTR_W-1:0] down = 4'hf - off;
		// odd quadrants mirror the table, even ones hold zero at their start
		assign tbl.mag[p] = idx[4] ? pt[down] : (off == 4'h0 ? 6'h00 : pt[up]); // see R14
		assign tbl.neg[p] = idx[5];
	end

endmodule

// [rtl/smp_position_ctrl.sv]
// serial driven microstep position control, top level
//
// Behaviour
// R1 - the phase index stays within 0 to 63 and every change wraps modulo 64.
// R2 - the step change is taken from bits 0 to 5 of each run register word.
// R3 - the step change is a signed two's complement value added to the index.
// R4 - one unit up is a sixteenth microstep forward, one unit down a sixteenth in reverse.
// R5 - the host sends 16, 8, 4 or 2 for full, half, quarter or eighth steps.
// R6 - the host repeats 000100 for forward quarter steps or 111100 for reverse ones.
// R7 - the host resends the other run register bits with every step change.
// R8 - the index moves only when the strobe rises at the end of a run register write.
// R9 - the step rate follows strobe rising edges alone, never the serial clock rate.
// R10 - everything but sleep is controlled over the serial link; the table restore comes from a write to the OFF_CTRL register instead.
// R11 - the host can reload the phase current table and the loaded profile is used.
// R12 - without any load the built-in sinusoidal profile is used.
// R13 - the resolution selects do not touch moves made through the step change field.
// R14 - each index gives one 6-bit current magnitude per phase from the table.
// R15 - a zero step change leaves the index alone but still updates the other run bits.
// R16 - the index is zero after reset and stays still between strobe rising edges.
module smp_position_ctrl
	import smp_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               sck_i,
	input  wire logic               sdi_i,
	input  wire logic               serial_strobe_n_i,
	input  wire logic               sleep_i,
	input  wire logic [BUS_AW-1:0]  reg_addr_i,
	input  wire logic [BUS_DW-1:0]  reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic [BUS_DW-1:0]       reg_rdata_o,
	output logic [IDX_W-1:0]        phase_index_o,
	output logic [MAG_W-1:0]        current_a_o,
	output logic [MAG_W-1:0]        current_b_o,
	output logic                    dir_a_o,
	output logic                    dir_b_o,
	output logic                    bridge_enable_o,
	output logic [5:0]              run_config_o,
	output logic                    resolution_select_lo_o,
	output logic                    resolution_select_hi_o
);

	// ****************************************
	// declarations
	// ****************************************
	logic [FRAME_W-1:0] rx_word;
	logic [BITS_W-1:0]  rx_bits;
	logic               strobe_meta;
	logic               strobe_sync;
	logic               sleep_meta;
	logic               sleep_sync;
	smp_link_state_t    state;
	smp_link_state_t    next_state;
	logic [IDX_W-1:0]   phase;
	logic [PT_PTR_W-1:0] tbl_ptr;
	logic [7:0]         good_count;
	logic [7:0]         bad_count;

	smp_table_if tbl ();

	// ****************************************
	// link side
	// ****************************************
	smp_link_rx u_rx (
		.sck_i             (sck_i),
		.sdi_i             (sdi_i),
		.serial_strobe_n_i (serial_strobe_n_i),
		.word_o            (rx_word),
		.bits_o            (rx_bits)
	);

	smp_phase_table u_table (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tbl   (tbl.table_side)
	);

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_meta <= 1'b1;
			strobe_sync <= 1'b1;
			sleep_meta  <= 1'b0;
			sleep_sync  <= 1'b0;
		end else begin
			strobe_meta <= serial_strobe_n_i;
			strobe_sync <= strobe_meta;
			sleep_meta  <= sleep_i;
			sleep_sync  <= sleep_meta;
		end
	end

	// ****************************************
	// frame sequencing
	// ****************************************
	// the word is read only after the synchronised strobe is seen high,
	// so the serial clock rate never sets when a step happens
	always_comb begin
		next_state = state;
		case (state)
			SMP_IDLE:   next_state = strobe_sync ? SMP_IDLE : SMP_FRAME;
			SMP_FRAME:  next_state = strobe_sync ? SMP_DECODE : SMP_FRAME; // see R9
			SMP_DECODE: next_state = SMP_IDLE;
			default:    next_state = SMP_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SMP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// frame decode
	// ****************************************
	wire        decode    = (state == SMP_DECODE);
	wire        frame_ok  = decode && (rx_bits == FRAME_BITS) && rx_word[WR_BIT];
	wire        frame_bad = decode && (rx_bits != FRAME_BITS);
	wire [1:0]  frame_reg = rx_word[ADDR_HI:ADDR_LO];
	wire        run_wr    = frame_ok && (frame_reg == RA_RUN); // see R8
	wire        cfg_wr    = frame_ok && (frame_reg == RA_CONFIG0); // see R10
	wire        tbl_wr    = frame_ok && (frame_reg == RA_TABLE);
	wire [IDX_W-1:0] step_change_field = rx_word[SC_HI:SC_LO]; // see R2
	// the resolution selects never enter this sum
	wire [IDX_W-1:0] next_phase = phase + step_change_field; // see R1, R3, R4, R13
	wire        tbl_clear = tbl_wr && rx_word[TBL_CLR_BIT];

	// ****************************************
	// phase index and run configuration
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= IDX_RESET; // see R16
		end else if (run_wr) begin
			phase <= next_phase; // see R15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_config_o <= '0;
		end else if (run_wr) begin
			run_config_o <= rx_word[RUN_CFG_HI:RUN_CFG_LO]; // see R15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resolution_select_lo_o <= 1'b0;
			resolution_select_hi_o <= 1'b0;
		end else if (cfg_wr) begin
			resolution_select_lo_o <= rx_word[RES_LO_BIT]; // see R10
			resolution_select_hi_o <= rx_word[RES_HI_BIT];
		end
	end

	// ****************************************
	// table loading
	// ****************************************
	// entries load in order from the first; a clear bit restarts the order
	always_ff @(posedge clk_i) begin
		if (rst_i || tbl_clear) begin
			tbl_ptr <= '0;
		end else if (tbl_wr) begin
			tbl_ptr <= tbl_ptr + 4'h1; // see R11
		end
	end

	wire restore_wr = reg_wr_i && (reg_addr_i == OFF_CTRL)
		&& reg_wdata_i[CTRL_RESTORE_BIT];

	assign tbl.index   = phase;
	assign tbl.wr_en   = tbl_wr && !tbl_clear;
	assign tbl.wr_ptr  = tbl_ptr;
	assign tbl.wr_data = rx_word[MAG_W-1:0];
	assign tbl.restore = restore_wr;

	// ****************************************
	// drive outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_index_o   <= IDX_RESET;
			current_a_o     <= '0;
			current_b_o     <= '0;
			dir_a_o         <= 1'b0;
			dir_b_o         <= 1'b0;
			bridge_enable_o <= 1'b0;
		end else begin
			phase_index_o   <= phase;
			current_a_o     <= tbl.mag[0]; // see R14
			current_b_o     <= tbl.mag[1];
			dir_a_o         <= tbl.neg[0];
			dir_b_o         <= tbl.neg[1];
			// sleep is the one control left on a pin
			bridge_enable_o <= run_config_o[RUN_EN_BIT-RUN_CFG_LO] && !sleep_sync;
		end
	end

	// ****************************************
	// frame counters
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			good_count <= '0;
			bad_count  <= '0;
		end else begin
			if (run_wr && good_count != 8'hff) begin
				good_count <= good_count + 8'h01;
			end
			if (frame_bad && bad_count != 8'hff) begin
				bad_count <= bad_count + 8'h01;
			end
		end
	end

	// ****************************************
	// software register port
	// ****************************************
	wire [BUS_DW-1:0] status_word  = {8'h00, bad_count, good_count, 2'h0, phase};
	wire [BUS_DW-1:0] current_word = {16'h0000, dir_b_o, 1'b0, current_b_o,
		dir_a_o, 1'b0, current_a_o};
	wire [BUS_DW-1:0] config_word  = {20'h00000, tbl_ptr, resolution_select_hi_o,
		resolution_select_lo_o, run_config_o};
	wire [BUS_DW-1:0] read_word    =
		(reg_addr_i == OFF_STATUS)  ? status_word  :
		(reg_addr_i == OFF_CURRENT) ? current_word :
		(reg_addr_i == OFF_CONFIG)  ? config_word  : 32'h00000000;

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? read_word : 32'h00000000;
		end
	end

	// ****************************************
	// elaboration checks
	// ****************************************
	if (STROBE_HIGH_MIN_CYC < 4) begin : g_bad_timing
		$error("strobe high time too short for the synchroniser");
	end

	// the wrap at 64 and the 6-bit magnitudes are built into the carrier
	if (IDX_W != 6 || MAG_W != 6 || FRAME_BITS != FRAME_W) begin : g_bad_width
		$error("index, magnitude or frame width not supported");
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_index_wraps_step: assert property ( // see R1
		run_wr |=> phase == IDX_W'($past(phase) + $past(step_change_field)))
		else $error("phase index did not add the step change modulo 64");

	a_signed_minus_one: assert property ( // see R3
		run_wr && step_change_field == 6'h3f |=> phase == $past(phase) - 6'h01)
		else $error("all ones step change did not step back by one");

	a_index_only_strobe: assert property ( // see R8
		!run_wr |=> $stable(phase))
		else $error("phase index moved without a strobed run write");

	a_strobe_to_step: assert property ( // see R9
		$rose(strobe_sync) && state == SMP_FRAME |=> decode)
		else $error("strobe rise not decoded on the next cycle");

	a_zero_step_hold: assert property ( // see R15
		run_wr && step_change_field == 6'h00
		|=> $stable(phase) && run_config_o == $past(rx_word[RUN_CFG_HI:RUN_CFG_LO]))
		else $error("zero step change moved the index or lost the run bits");

	a_index_after_reset: assert property ( // see R16
		disable iff (1'b0) rst_i |=> phase == IDX_RESET && phase_index_o == IDX_RESET)
		else $error("phase index not zero after reset");

	a_current_lookup: assert property ( // see R14
		$stable(phase) [*2] |-> current_a_o == $past(tbl.mag[0])
		&& current_b_o == $past(tbl.mag[1]))
		else $error("phase current output does not follow the table");

	a_default_peak: assert property ( // see R12
		good_count == 8'h00 && !tbl_wr && phase == 6'h00 ##1 $stable(phase)
		|-> current_b_o == 6'h3f && current_a_o == 6'h00)
		else $error("default profile wrong at index zero");

	a_config_select: assert property ( // see R10
		cfg_wr |=> resolution_select_lo_o == $past(rx_word[RES_LO_BIT])
		&& resolution_select_hi_o == $past(rx_word[RES_HI_BIT]))
		else $error("resolution selects not loaded from the serial link");

	a_table_pointer: assert property ( // see R11
		tbl_wr && !tbl_clear |=> tbl_ptr == $past(tbl_ptr) + 4'h1)
		else $error("table load pointer did not advance");

	a_sleep_disables: assert property ( // see R10
		sleep_sync |=> !bridge_enable_o)
		else $error("bridge enabled during sleep");

	a_bad_frame_ignored: assert property ( // see R8
		frame_bad |=> $stable(phase) && $stable(run_config_o))
		else $error("frame with a wrong bit count changed the index");

	a_bad_count_step: assert property ( // see R8
		frame_bad && bad_count != 8'hff |=> bad_count == $past(bad_count) + 8'h01)
		else $error("wrong length frame not counted");

	a_run_config_load: assert property ( // see R15
		run_wr |=> run_config_o == $past(rx_word[RUN_CFG_HI:RUN_CFG_LO]))
		else $error("run bits not taken from the run write");

	a_read_data_once: assert property (
		!reg_rd_i |=> reg_rdata_o == 32'h00000000)
		else $error("read data stood longer than one cycle");

	a_dir_from_index: assert property ( // see R14
		1'b1 |=> dir_a_o == $past(phase[5]) && dir_b_o == $past(phase[5] ^ phase[4]))
		else $error("phase direction does not follow the index quadrant");

	a_decode_single: assert property ( // see R9
		decode |=> state == SMP_IDLE)
		else $error("frame decoded more than once");

	a_table_clear: assert property ( // see R11
		tbl_clear |=> tbl_ptr == 4'h0)
		else $error("table clear did not restart the load order");

	c_forward_quarter: cover property (run_wr && step_change_field == 6'h04);
	c_reverse_wrap: cover property (run_wr && phase == 6'h00 && step_change_field == 6'h3c);
	c_table_load: cover property (tbl_wr ##[1:200] run_wr);
	c_bad_frame: cover property (frame_bad);
	c_sleep_cycle: cover property (sleep_sync ##1 !sleep_sync);

endmodule

// [verif/smp_host_model.sv]
// host side model that drives frames onto the three-wire link
module smp_host_model (
	output logic sck_o,
	output logic sdi_o,
	output logic serial_strobe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_NS = 32;

	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
		serial_strobe_n_o = 1'b1;
		// the link side has no reset; a short strobe pulse at power-up
		// gives it the rising edge that arms its bit count
		#1;
		serial_strobe_n_o = 1'b0;
		#1;
		serial_strobe_n_o = 1'b1;
	end

	// link clock ticks only inside a frame; sdi turns to junk outside it
	task automatic send(input logic [15:0] word, input int nbits);
		#23;
		serial_strobe_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			sdi_o = word[15-i];
			#(HALF_NS);
			sck_o = 1'b1;
			#(HALF_NS);
			sck_o = 1'b0;
		end
		#(HALF_NS);
		serial_strobe_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask
endmodule

// [verif/serial_microstep_position_control_tb.sv]
// self-checking bench for the serial microstep position logic
module serial_microstep_position_control_tb import smp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              sleep_i = 1'b0;
	logic [BUS_AW-1:0] reg_addr = '0;
	logic [BUS_DW-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [BUS_DW-1:0] reg_rdata;
	logic              sck, sdi, strobe_n;
	logic [IDX_W-1:0]  phase;
	logic [MAG_W-1:0]  cur_a, cur_b;
	logic              dir_a, dir_b, bridge_en, res_lo, res_hi;
	logic [5:0]        run_cfg;
	int                err_total = 0;
	int                n_checks = 0;
	int                seed = 32'he1d4;
	logic [5:0]        exp_idx = '0, exp_cfg = '0, exp_b;
	logic [5:0]        exp_tbl [PT_N];
	logic [7:0]        exp_good = '0, exp_bad = '0;
	logic [1:0]        exp_res = '0;
	// sums to zero, then crosses the 63/0 seam, then repeated quarter steps
	logic [5:0]        steps [23] = '{6'h10, 6'h30, 6'h08, 6'h38, 6'h04, 6'h3c, 6'h02,
		6'h3e, 6'h01, 6'h3f, 6'h00, 6'h3f, 6'h02, 6'h3e, 6'h01,
		6'h04, 6'h04, 6'h04, 6'h04, 6'h3c, 6'h3c, 6'h3c, 6'h3c};

	smp_position_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .sdi_i(sdi),
		.serial_strobe_n_i(strobe_n), .sleep_i(sleep_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .phase_index_o(phase), .current_a_o(cur_a),
		.current_b_o(cur_b), .dir_a_o(dir_a), .dir_b_o(dir_b),
		.bridge_enable_o(bridge_en), .run_config_o(run_cfg),
		.resolution_select_lo_o(res_lo), .resolution_select_hi_o(res_hi));

	smp_host_model i_host (.sck_o(sck), .sdi_o(sdi), .serial_strobe_n_o(strobe_n));

	always #50 clk_i = ~clk_i;

	// ****
	// compare and report
	// ****
	task automatic chk_field(input string what, input logic [5:0] exp, input logic [5:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****
	// expectations
	// ****
	function automatic logic [5:0] cur_of(input logic [5:0] idx);
		logic [3:0] o;
		o = idx[3:0];
		if (idx[4]) return exp_tbl[4'hf - o];
		return (o == 4'h0) ? 6'h00 : exp_tbl[o - 4'h1];
	endfunction

	task automatic check_all();
		exp_b = exp_idx + 6'h10;
		chk_field("phase", exp_idx, phase);
		chk_field("current_a", cur_of(exp_idx), cur_a);
		chk_field("current_b", cur_of(exp_b), cur_b);
		chk_field("dir_a", {5'h0, exp_idx[5]}, {5'h0, dir_a});
		chk_field("dir_b", {5'h0, exp_b[5]}, {5'h0, dir_b});
		chk_field("run_config", exp_cfg, run_cfg);
		chk_field("bridge", {5'h0, exp_cfg[0] & ~sleep_i}, {5'h0, bridge_en});
	endtask

	// ****
	// link and register access
	// ****
	// nine cycles cover the strobe synchroniser, decode and output register
	task automatic frame(input logic [15:0] w, input int n);
		i_host.send(w, n);
		repeat (9) @(posedge clk_i);
		if (n == 16 && w[WR_BIT] && w[ADDR_HI:ADDR_LO] == RA_RUN) exp_good++;
		if (n != 16) exp_bad++;
	endtask

	task automatic step(input logic [5:0] cfg, input logic [5:0] sc);
		frame({RA_RUN, 2'b10, cfg, sc}, 16);
		exp_idx = exp_idx + sc;
		exp_cfg = cfg;
		check_all();
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		chk_word("reg_rdata", e, reg_rdata);
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		for (int i = 0; i < PT_N; i++) exp_tbl[i] = PT_DEFAULT[i];
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check_all();
		foreach (steps[i]) step(6'($random(seed)), steps[i]);
		for (int i = 0; i < 20; i++) step(6'($random(seed)), 6'($random(seed)));
		frame({RA_RUN, 2'b10, 6'h15, 6'h05}, 15);
		check_all();
		frame({RA_RUN, 2'b00, 6'h15, 6'h05}, 16);
		check_all();
		frame({RA_CONFIG0, 2'b10, 10'h000, 2'b11}, 16);
		exp_res = 2'h3;
		chk_field("res", {4'h0, exp_res}, {4'h0, res_hi, res_lo});
		step(6'h01, 6'h01);
		step(6'h01, 6'h00);
		sleep_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check_all();
		sleep_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check_all();
		frame({RA_TABLE, 2'b10, 6'h01, 6'h00}, 16);
		for (int i = 0; i < PT_N; i++) begin
			exp_tbl[i] = 6'($random(seed));
			frame({RA_TABLE, 2'b10, 6'h00, exp_tbl[i]}, 16);
		end
		for (int i = 0; i < 6; i++) step(exp_cfg, 6'h05);
		exp_b = exp_idx + 6'h10;
		rd(OFF_STATUS, {8'h0, exp_bad, exp_good, 2'h0, exp_idx});
		rd(OFF_CURRENT, {16'h0, exp_b[5], 1'b0, cur_of(exp_b), exp_idx[5], 1'b0,
			cur_of(exp_idx)});
		rd(OFF_CONFIG, {20'h0, 4'h0, exp_res, exp_cfg});
		rd(4'h6, 32'h0);
		rd(OFF_CTRL, 32'h0);
		wr(4'h6, 32'hffff_ffff);
		wr(OFF_CTRL, 32'h1);
		for (int i = 0; i < PT_N; i++) exp_tbl[i] = PT_DEFAULT[i];
		repeat (4) @(posedge clk_i);
		check_all();
		summarize();
	end

	// a hung run counts as a failure
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		summarize();
	end
endmodule
